// >>> include/ulms_pkg.sv
// Constants and types for the UART line and modem status block.
// Behaviour
// - Data ready while any received character waits.
// - Overrun when character completes into full FIFO.
// - Overrun character is dropped, FIFO kept intact.
// - Overrun interrupts at once; errors at head.
// - Parity error tagged to head character.
// - Framing error tagged to head character.
// - Break loads one character, holds until high.
// - Holding-empty follows holding register or FIFO empty.
// - Transmitter empty when holding and shift empty.
// - FIFO error while any stored byte tagged.
// - Request-to-send leads first byte by setup.
// - Request-to-send trails last byte by turnaround.
// - Lower nibble selects flow control hysteresis.
// - Delta flags on CTS, DSR, CD change.
// - Ring delta only on ring low-to-high.
// - Modem interrupt when delta set and enabled.
// - Status bits are complements of modem inputs.
// - Loopback status mirrors modem control bits.
// - CTS high pauses after current character.
// - Loopback bit selects internal loopback mode.
`default_nettype none
package ulms_pkg;
	// ================================================================
	// Register map
	localparam logic [2:0] ADDR_LINE_STATUS   = 3'h5;
	localparam logic [2:0] ADDR_MODEM_STATUS  = 3'h6;
	localparam logic [2:0] ADDR_TIMING_HYST   = 3'h7;
	localparam logic [2:0] ADDR_MODEM_CONTROL = 3'h4;
	localparam logic [2:0] ADDR_INT_ENABLE    = 3'h1;
	localparam logic [2:0] ADDR_FEATURE_CTRL  = 3'h2;
	// ================================================================
	// Field positions
	localparam int IEN_LINE   = 2;
	localparam int IEN_MODEM  = 3;
	localparam int MC_RTS     = 1;
	localparam int MC_DTR     = 0;
	localparam int MC_OUT1    = 2;
	localparam int MC_OUT2    = 3;
	localparam int MC_LOOP    = 4;
	localparam int FC_FIFO    = 0;
	localparam int FC_RS485   = 3;
	localparam int FC_AUTOCTS = 1;
	localparam int FC_AUTORTS = 2;
	localparam logic [7:0] RESET_ZERO = 8'h00;
	// ================================================================
	// Transmitter direction states
	typedef enum logic [3:0] {
		ULMS_IDLE  = 4'b0001,
		ULMS_SETUP = 4'b0010,
		ULMS_SEND  = 4'b0100,
		ULMS_HOLD  = 4'b1000
	} ulms_dir_t;
	// ================================================================
	// Hysteresis lookup by code.
	function automatic logic [5:0] ulms_hyst(input logic [3:0] code);
		case (code)
			4'h0: ulms_hyst = 6'h00;
			4'h1: ulms_hyst = 6'h04;
			4'h2: ulms_hyst = 6'h06;
			4'h3: ulms_hyst = 6'h08;
			4'h4: ulms_hyst = 6'h08;
			4'h5: ulms_hyst = 6'h10;
			4'h6: ulms_hyst = 6'h18;
			4'h7: ulms_hyst = 6'h20;
			4'h8: ulms_hyst = 6'h28;
			4'h9: ulms_hyst = 6'h2C;
			4'hA: ulms_hyst = 6'h30;
			4'hB: ulms_hyst = 6'h34;
			4'hC: ulms_hyst = 6'h0C;
			4'hD: ulms_hyst = 6'h14;
			4'hE: ulms_hyst = 6'h1C;
			default: ulms_hyst = 6'h24;
		endcase
	endfunction
endpackage
`default_nettype wire

// >>> src/ulms_status.sv
// Line status, modem status and RS-485 direction logic of a UART.
//
// Local design decisions: the placing of the registers and the address-and-strobe port.
`default_nettype none
module ulms_status
	import ulms_pkg::*;
#(
	parameter int DEPTH = 16,
	parameter int AW    = 4
) (
	// Clock and reset
	input  wire logic       CLK,
	input  wire logic       RESET,
	// Register port
	input  wire logic [2:0] ADDR,
	input  wire logic [7:0] WDATA,
	input  wire logic       WR,
	input  wire logic       RD,
	output logic      [7:0] RDATA,
	// Receiver side: completed character with its tags
	input  wire logic       RX_DONE,
	input  wire logic [7:0] RX_CHAR,
	input  wire logic       RX_PARITY_ERR,
	input  wire logic       RX_FRAME_ERR,
	input  wire logic       RX_BREAK,
	input  wire logic       RX_LINE,
	input  wire logic       RX_POP,
	output logic      [7:0] RX_HEAD,
	output logic      [AW:0] RX_LEVEL,
	// Transmitter side
	input  wire logic       TX_LOAD,
	input  wire logic       TX_TAKE,
	input  wire logic       TX_SHIFT_BUSY,
	input  wire logic       TX_FIFO_EMPTY,
	input  wire logic       BIT_TICK,
	output logic            TX_ALLOW,
	// Modem pins, active low
	input  wire logic       CTS_N,
	input  wire logic       DSR_N,
	input  wire logic       RI_N,
	input  wire logic       CD_N,
	output logic            RTS_N,
	output logic            DTR_N,
	// Flow control and interrupts
	output logic      [5:0] HYSTERESIS,
	output logic            LOOPBACK,
	output logic            LINE_IRQ,
	output logic            MODEM_IRQ
);
	// ================================================================
	// Control registers
	logic [7:0] int_enable_reg;
	logic [7:0] modem_control;
	logic [7:0] feature_control;
	logic [7:0] rs485_timing_hysteresis;

	always_ff @(posedge CLK) begin
		if (RESET) begin
			int_enable_reg          <= RESET_ZERO;
			modem_control           <= RESET_ZERO;
			feature_control         <= RESET_ZERO;
			rs485_timing_hysteresis <= RESET_ZERO;
		end else if (WR) begin
			case (ADDR)
				ADDR_INT_ENABLE:    int_enable_reg <= WDATA;
				ADDR_MODEM_CONTROL: modem_control <= WDATA;
				ADDR_FEATURE_CTRL:  feature_control <= WDATA;
				ADDR_TIMING_HYST:   rs485_timing_hysteresis <= WDATA;
				default: ;
			endcase
		end
	end

	assign LOOPBACK   = modem_control[MC_LOOP];
	assign HYSTERESIS = (feature_control[FC_AUTORTS])
		? ulms_hyst(rs485_timing_hysteresis[3:0]) : 6'h00;

	// ================================================================
	// Receive FIFO with per-byte tags: parity, framing, break.
	logic [7:0]    mem_data [DEPTH];
	logic [2:0]    mem_tag  [DEPTH];
	logic [AW-1:0] wptr;
	logic [AW-1:0] rptr;
	logic [AW:0]   count;
	logic [AW:0]   err_count;
	logic          full;
	logic          empty;
	logic          push;
	logic          pop;
	logic          break_hold;
	logic [2:0]    in_tag;
	logic [2:0]    head_tag;
	logic          push_err;
	logic          pop_err;

	assign full   = (count == (AW+1)'(DEPTH));
	assign empty  = (count == '0);
	assign in_tag = {RX_BREAK, RX_FRAME_ERR, RX_PARITY_ERR};
	// A full FIFO drops the new character so stored data stay intact.
	assign push   = RX_DONE && !full
		&& !(RX_BREAK && break_hold);
	assign pop    = RX_POP && !empty;
	assign head_tag = empty ? 3'h0 : mem_tag[rptr];
	assign push_err = push && (in_tag != 3'h0);
	assign pop_err  = pop && (head_tag != 3'h0);

	always_ff @(posedge CLK) begin
		if (push) begin
			mem_data[wptr] <= RX_CHAR;
			mem_tag[wptr]  <= in_tag;
		end
	end

	always_ff @(posedge CLK) begin
		if (RESET) begin
			wptr  <= '0;
			rptr  <= '0;
			count <= '0;
		end else begin
			if (push)
				wptr <= wptr + 1'b1;
			if (pop)
				rptr <= rptr + 1'b1;
			count <= count + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

	always_ff @(posedge CLK) begin
		if (RESET)
			err_count <= '0;
		else
			err_count <= err_count + (AW+1)'(push_err)
				- (AW+1)'(pop_err);
	end

	// One break character per break; released when the line goes high.
	always_ff @(posedge CLK) begin
		if (RESET)
			break_hold <= 1'b0;
		else if (RX_DONE && RX_BREAK)
			break_hold <= 1'b1;
		else if (RX_LINE)
			break_hold <= 1'b0;
	end

	always_ff @(posedge CLK) begin
		if (RESET)
			RX_HEAD <= RESET_ZERO;
		else
			RX_HEAD <= empty ? RESET_ZERO : mem_data[rptr];
	end
	assign RX_LEVEL = count;

	// ================================================================
	// Line status
	logic overrun;
	logic rd_line;
	logic thr_empty;
	logic [7:0] line_status;

	assign rd_line = RD && (ADDR == ADDR_LINE_STATUS);

	always_ff @(posedge CLK) begin
		if (RESET)
			overrun <= 1'b0;
		else if (RX_DONE && full)
			overrun <= 1'b1;
		else if (rd_line)
			overrun <= 1'b0;
	end

	// Without FIFO the holding byte empties on take and fills on load.
	always_ff @(posedge CLK) begin
		if (RESET)
			thr_empty <= 1'b1;
		else if (TX_LOAD)
			thr_empty <= 1'b0;
		else if (TX_TAKE)
			thr_empty <= 1'b1;
	end

	logic hold_empty;
	assign hold_empty = feature_control[FC_FIFO] ? TX_FIFO_EMPTY
		: thr_empty;

	always_comb begin
		line_status    = RESET_ZERO;
		line_status[0] = !empty;
		line_status[1] = overrun;
		line_status[2] = head_tag[0];
		line_status[3] = head_tag[1];
		line_status[4] = head_tag[2] || break_hold;
		line_status[5] = hold_empty;
		line_status[6] = hold_empty && !TX_SHIFT_BUSY;
		line_status[7] = (err_count != '0);
	end

	always_ff @(posedge CLK) begin
		if (RESET)
			LINE_IRQ <= 1'b0;
		else
			LINE_IRQ <= int_enable_reg[IEN_LINE]
				&& (overrun || (head_tag != 3'h0));
	end

	// ================================================================
	// Modem status
	logic [3:0] level;
	logic [3:0] level_q;
	logic [3:0] delta;
	logic [3:0] set_delta;
	logic       rd_modem;
	logic       seeded;

	assign rd_modem = RD && (ADDR == ADDR_MODEM_STATUS);

	always_comb begin
		if (modem_control[MC_LOOP])
			level = {modem_control[MC_OUT2], modem_control[MC_OUT1],
				modem_control[MC_DTR], modem_control[MC_RTS]};
		else
			level = {!CD_N, !RI_N, !DSR_N, !CTS_N};
	end

	always_comb begin
		set_delta    = level ^ level_q;
		set_delta[2] = level_q[2] && !level[2];
		if (!seeded)
			set_delta = 4'h0;
	end

	always_ff @(posedge CLK) begin
		if (RESET) begin
			level_q <= 4'h0;
			seeded  <= 1'b0;
		end else begin
			level_q <= level;
			seeded  <= 1'b1;
		end
	end

	// A change in the read cycle survives the clear.
	always_ff @(posedge CLK) begin
		if (RESET)
			delta <= 4'h0;
		else if (rd_modem)
			delta <= set_delta;
		else
			delta <= delta | set_delta;
	end

	always_ff @(posedge CLK) begin
		if (RESET)
			MODEM_IRQ <= 1'b0;
		else
			MODEM_IRQ <= int_enable_reg[IEN_MODEM]
				&& (delta != 4'h0);
	end

	// ================================================================
	// Read port
	always_ff @(posedge CLK) begin
		if (RESET)
			RDATA <= RESET_ZERO;
		else if (RD) begin
			case (ADDR)
				ADDR_LINE_STATUS:   RDATA <= line_status;
				ADDR_MODEM_STATUS:  RDATA <= {level, delta};
				ADDR_INT_ENABLE:    RDATA <= int_enable_reg;
				ADDR_MODEM_CONTROL: RDATA <= modem_control;
				ADDR_FEATURE_CTRL:  RDATA <= feature_control;
				default:            RDATA <= RESET_ZERO;
			endcase
		end
	end

	// ================================================================
	// RS-485 direction control, counted in bit ticks.
	ulms_dir_t  state;
	logic [3:0] bits;
	logic       tx_pending;
	logic       rs485;

	assign rs485      = feature_control[FC_RS485];
	assign tx_pending = !hold_empty || TX_SHIFT_BUSY;

	always_ff @(posedge CLK) begin
		if (RESET) begin
			state <= ULMS_IDLE;
			bits  <= 4'h0;
		end else begin
			case (state)
				ULMS_IDLE: begin
					bits <= 4'h0;
					if (rs485 && tx_pending)
						state <= ULMS_SETUP;
				end
				ULMS_SETUP: begin
					if (bits == rs485_timing_hysteresis[7:4]) begin
						state <= ULMS_SEND;
						bits  <= 4'h0;
					end else if (BIT_TICK)
						bits <= bits + 4'h1;
				end
				ULMS_SEND: begin
					bits <= 4'h0;
					if (!tx_pending)
						state <= ULMS_HOLD;
				end
				ULMS_HOLD: begin
					if (tx_pending)
						state <= ULMS_SEND;
					else if (bits == rs485_timing_hysteresis[3:0])
						state <= ULMS_IDLE;
					else if (BIT_TICK)
						bits <= bits + 4'h1;
				end
				default: state <= ULMS_IDLE;
			endcase
		end
	end

	// ================================================================
	// Pin drive and transmit permission
	logic rts_active;
	// The pin goes active with the move into setup, so every tick that
	// the setup count takes comes after the pin has changed.
	assign rts_active = rs485 ? (state != ULMS_IDLE || tx_pending)
		: modem_control[MC_RTS];

	always_ff @(posedge CLK) begin
		if (RESET) begin
			RTS_N <= 1'b1;
			DTR_N <= 1'b1;
		end else begin
			RTS_N <= !(rts_active && !modem_control[MC_LOOP]);
			DTR_N <= !(modem_control[MC_DTR]
				&& !modem_control[MC_LOOP]);
		end
	end

	// The transmitter checks this only between characters, so a pause
	// never cuts a character short.
	assign TX_ALLOW = (!feature_control[FC_AUTOCTS] || level[0])
		&& (!rs485 || state == ULMS_SEND);
endmodule
`default_nettype wire

// >>> testbench/tb_top.sv
// Self-checking bench of the UART status block.
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin num_errors++; \
	$display("ERROR %0t got %h exp %h", $time, g, e); end end
module tb_top;
	import ulms_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic       CLK, RESET, WR, RD, RX_DONE, RX_PARITY_ERR, RX_FRAME_ERR;
	logic       RX_BREAK, RX_POP, TX_LOAD, TX_TAKE, TX_SHIFT_BUSY;
	logic       TX_FIFO_EMPTY, TX_ALLOW, RTS_N, DTR_N, LOOPBACK;
	logic       LINE_IRQ, MODEM_IRQ, CTS_N, DSR_N, RI_N, CD_N, RX_LINE;
	logic [2:0] ADDR;
	logic [7:0] WDATA, RDATA, RX_CHAR, RX_HEAD;
	logic [4:0] RX_LEVEL;
	logic [5:0] HYSTERESIS;
	logic [1:0] tc = 2'h0;
	logic       BIT_TICK = 1'b0;
	int         num_errors = 0;
	int         n_checks = 0;
	ulms_status uut (.*);
	ulms_modem_model peer (.CLK, .CTS_N, .DSR_N, .RI_N, .CD_N, .RX_LINE);
	initial begin
		CLK = 1'b0;
		forever #4 CLK = ~CLK;
	end
	// Bit time of four clocks keeps the delay counts short.
	always @(posedge CLK) begin
		tc <= tc + 2'h1;
		BIT_TICK <= &tc;
	end
	// ======================================
	// Bus and receiver tasks.
	task wr(input logic [2:0] a, input logic [7:0] d);
		ADDR <= a;
		WDATA <= d;
		WR <= 1'b1;
		@(posedge CLK);
		WR <= 1'b0;
		@(posedge CLK);
	endtask
	task rd(input logic [2:0] a, input logic [7:0] e, m);
		ADDR <= a;
		RD <= 1'b1;
		@(posedge CLK);
		RD <= 1'b0;
		#1 `CHK(RDATA & m, e)
		@(posedge CLK);
	endtask
	task rx(input logic [10:0] v);
		{RX_PARITY_ERR, RX_FRAME_ERR, RX_BREAK, RX_CHAR} <= v;
		RX_DONE <= 1'b1;
		@(posedge CLK);
		RX_DONE <= 1'b0;
		@(posedge CLK);
	endtask
	task pop;
		RX_POP <= 1'b1;
		@(posedge CLK);
		RX_POP <= 1'b0;
		@(posedge CLK);
	endtask
	task stop_test;
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// ======================================
	// Scenarios.
	task t_rx;
		wr(ADDR_INT_ENABLE, 8'h04);
		rx(11'h441);
		rx(11'h242);
		rx(11'h043);
		rd(ADDR_LINE_STATUS, 8'h85, 8'h9F);
		`CHK(RX_HEAD, 8'h41)
		`CHK(LINE_IRQ, 1'b1)
		pop;
		rd(ADDR_LINE_STATUS, 8'h89, 8'h9F);
		pop;
		rd(ADDR_LINE_STATUS, 8'h01, 8'h9F);
		`CHK(RX_HEAD, 8'h43)
		pop;
		rd(ADDR_LINE_STATUS, 8'h00, 8'h9F);
	endtask
	task t_ovr;
		for (int i = 0; i < 17; i++) rx({3'h0, 8'(i)});
		`CHK(RX_LEVEL, 5'h10)
		@(posedge CLK);
		`CHK(LINE_IRQ, 1'b1)
		rd(ADDR_LINE_STATUS, 8'h03, 8'h9F);
		rd(ADDR_LINE_STATUS, 8'h01, 8'h9F);
		for (int i = 0; i < 15; i++) pop;
		@(posedge CLK);
		`CHK(RX_HEAD, 8'h0F)
		pop;
		pop;
		`CHK(RX_LEVEL, 5'h00)
	endtask
	task t_brk;
		peer.drive(5'h1E);
		rx(11'h100);
		rx(11'h100);
		`CHK(RX_LEVEL, 5'h01)
		rd(ADDR_LINE_STATUS, 8'h91, 8'h9F);
		peer.drive(5'h1F);
		pop;
	endtask
	task t_modem;
		wr(ADDR_INT_ENABLE, 8'h08);
		wr(ADDR_FEATURE_CTRL, 8'h02);
		rd(ADDR_MODEM_STATUS, 8'h00, 8'hFF);
		peer.drive(5'h0F);
		repeat (4) @(posedge CLK);
		`CHK(MODEM_IRQ, 1'b1)
		`CHK(TX_ALLOW, 1'b1)
		rd(ADDR_MODEM_STATUS, 8'h11, 8'hFF);
		rd(ADDR_MODEM_STATUS, 8'h10, 8'hFF);
		peer.drive(5'h13);
		repeat (4) @(posedge CLK);
		`CHK(TX_ALLOW, 1'b0)
		rd(ADDR_MODEM_STATUS, 8'h63, 8'hFF);
		peer.drive(5'h1F);
		repeat (4) @(posedge CLK);
		rd(ADDR_MODEM_STATUS, 8'h06, 8'hFF);
		peer.drive(5'h1D);
		repeat (4) @(posedge CLK);
		rd(ADDR_MODEM_STATUS, 8'h88, 8'hFF);
		wr(ADDR_MODEM_CONTROL, 8'h16);
		rd(ADDR_MODEM_STATUS, 8'h50, 8'hF0);
		`CHK(RTS_N, 1'b1)
		wr(ADDR_MODEM_CONTROL, 8'h03);
		rd(ADDR_MODEM_STATUS, 8'h80, 8'hF0);
		`CHK({RTS_N, DTR_N, LOOPBACK}, 3'h0)
	endtask
	task t_hyst;
		logic [5:0] h [16] = '{6'h00, 6'h04, 6'h06, 6'h08, 6'h08, 6'h10,
			6'h18, 6'h20, 6'h28, 6'h2C, 6'h30, 6'h34,
			6'h0C, 6'h14, 6'h1C, 6'h24};
		wr(ADDR_FEATURE_CTRL, 8'h05);
		TX_FIFO_EMPTY <= 1'b0;
		rd(ADDR_LINE_STATUS, 8'h00, 8'h60);
		TX_FIFO_EMPTY <= 1'b1;
		rd(ADDR_LINE_STATUS, 8'h60, 8'h60);
		rd(ADDR_TIMING_HYST, 8'h00, 8'hFF);
		for (int i = 0; i < 16; i++) begin
			wr(ADDR_TIMING_HYST, {4'h0, 4'(i)});
			`CHK(HYSTERESIS, h[i])
		end
	endtask
	task t_485;
		int n;
		wr(ADDR_FEATURE_CTRL, 8'h08);
		wr(ADDR_TIMING_HYST, 8'h32);
		TX_LOAD <= 1'b1;
		@(posedge CLK);
		TX_LOAD <= 1'b0;
		n = 0;
		for (int i = 0; i < 200 && !TX_ALLOW; i++) begin
			n += BIT_TICK && !RTS_N;
			@(posedge CLK);
		end
		`CHK(n, 3)
		rd(ADDR_LINE_STATUS, 8'h00, 8'h60);
		{TX_TAKE, TX_SHIFT_BUSY} <= 2'h3;
		@(posedge CLK);
		TX_TAKE <= 1'b0;
		rd(ADDR_LINE_STATUS, 8'h20, 8'h60);
		TX_SHIFT_BUSY <= 1'b0;
		// Ticks count from the first edge after the shifter is seen idle.
		@(posedge CLK);
		n = 0;
		for (int i = 0; i < 200 && !RTS_N; i++) begin
			@(posedge CLK);
			n += BIT_TICK && !RTS_N;
		end
		`CHK(n, 2)
		rd(ADDR_LINE_STATUS, 8'h60, 8'h60);
	endtask
	initial begin
		repeat (20000) @(posedge CLK);
		num_errors++;
		stop_test;
	end
	initial begin
		{ADDR, WDATA, WR, RD, RX_DONE, RX_CHAR, RX_POP, TX_LOAD} = '0;
		{RX_PARITY_ERR, RX_FRAME_ERR, RX_BREAK, TX_TAKE} = '0;
		TX_SHIFT_BUSY = 1'b0;
		TX_FIFO_EMPTY = 1'b1;
		RESET = 1'b1;
		repeat (5) @(posedge CLK);
		RESET <= 1'b0;
		@(posedge CLK);
		rd(ADDR_LINE_STATUS, 8'h60, 8'hFF);
		t_rx;
		t_ovr;
		t_brk;
		t_modem;
		t_hyst;
		t_485;
		stop_test;
	end
endmodule
`default_nettype wire

// >>> testbench/ulms_modem_model.sv
// Remote modem and serial line facing the status block.
`default_nettype none
module ulms_modem_model (
	input  wire logic CLK,
	output logic      CTS_N,
	output logic      DSR_N,
	output logic      RI_N,
	output logic      CD_N,
	output logic      RX_LINE
);
	timeunit 1ns;
	timeprecision 1ps;
	// Lines idle inactive high; a high clear-to-send asks for a pause.
	task automatic drive(input logic [4:0] v);
		{CTS_N, DSR_N, RI_N, CD_N, RX_LINE} <= v;
	endtask
	initial {CTS_N, DSR_N, RI_N, CD_N, RX_LINE} = 5'h1F;
endmodule
`default_nettype wire

// >>> testbench/ulms_status_properties.sv
// Port checker of the UART status block.
`default_nettype none
module ulms_props
	import ulms_pkg::*;
#(
	parameter int DEPTH = 16,
	parameter int AW    = 4
) (
	input wire logic        CLK,
	input wire logic        RESET,
	input wire logic [2:0]  ADDR,
	input wire logic [7:0]  WDATA,
	input wire logic        WR,
	input wire logic        RX_DONE,
	input wire logic        RX_BREAK,
	input wire logic        RX_POP,
	input wire logic [AW:0] RX_LEVEL,
	input wire logic        CTS_N,
	input wire logic        TX_ALLOW,
	input wire logic        RTS_N,
	input wire logic        DTR_N,
	input wire logic        LOOPBACK,
	input wire logic        LINE_IRQ,
	input wire logic        MODEM_IRQ
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] mc;
	logic [7:0] ien;
	logic [7:0] fc;
	default clocking @(posedge CLK); endclocking
	default disable iff (RESET);
	always_ff @(posedge CLK) begin
		if (RESET) begin
			mc <= 8'h00;
			ien <= 8'h00;
			fc <= 8'h00;
		end else if (WR) begin
			if (ADDR == ADDR_MODEM_CONTROL) mc <= WDATA;
			if (ADDR == ADDR_INT_ENABLE) ien <= WDATA;
			if (ADDR == ADDR_FEATURE_CTRL) fc <= WDATA;
		end
	end
	// ======================================
	// A break is left out: a repeated one is dropped.
	AST_LEVEL_INC: assert property (RX_DONE && !RX_POP && !RX_BREAK
		&& RX_LEVEL < DEPTH |=> RX_LEVEL == $past(RX_LEVEL) + 1)
		else $error("level did not rise");
	AST_FULL_KEEP: assert property (RX_DONE && !RX_POP
		&& RX_LEVEL == DEPTH |=> RX_LEVEL == DEPTH)
		else $error("full FIFO changed");
	AST_LOOP: assert property (LOOPBACK == mc[MC_LOOP])
		else $error("loopback mode wrong");
	AST_LOOP_PINS: assert property (LOOPBACK && $past(LOOPBACK)
		|-> RTS_N && DTR_N)
		else $error("pins driven in loopback");
	AST_LIRQ_OFF: assert property (!ien[IEN_LINE]
		&& !$past(ien[IEN_LINE]) |-> !LINE_IRQ)
		else $error("line irq while disabled");
	AST_MIRQ_OFF: assert property (!ien[IEN_MODEM]
		&& !$past(ien[IEN_MODEM]) |-> !MODEM_IRQ)
		else $error("modem irq while disabled");
	AST_CTS_DELTA: assert property (ien[IEN_MODEM] && !LOOPBACK
		&& $changed(CTS_N) && !$past(RESET) |-> ##[1:3] MODEM_IRQ)
		else $error("no irq on clear-to-send change");
	AST_CTS_PAUSE: assert property ((CTS_N && fc[FC_AUTOCTS]
		&& !LOOPBACK)[*3] |-> !TX_ALLOW)
		else $error("sending while paused");
endmodule
bind ulms_status ulms_props #(.DEPTH(DEPTH), .AW(AW)) u_props (.*);
`default_nettype wire
